/* File: hdl/abd_char_match.sv */
`default_nettype none
module abd_char_match (
  // Received character
  input  wire logic                       char_valid,
  input  wire logic [abd_pkg::CHAR_W-1:0] char_data,
  // Classification
  output abd_pkg::abd_hit_t               hit
);

  // Exact 8-bit compare; parity or ninth bit is stripped upstream
  always_comb begin
    hit.lower_a = char_valid && (char_data == abd_pkg::CHAR_LOWER_A);
    hit.upper_a = char_valid && (char_data == abd_pkg::CHAR_UPPER_A);
    hit.lower_t = char_valid && (char_data == abd_pkg::CHAR_LOWER_T);
    hit.upper_t = char_valid && (char_data == abd_pkg::CHAR_UPPER_T);
  end

endmodule
`default_nettype wire

/* File: hdl/abd_pkg.sv */
`default_nettype none
package abd_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned LVL_W  = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_RXQ  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_RCV  = 4'h3;

  // Control and status widths (bits 0 upward)
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned STAT_W = 5;

  // Receive queue control and receiver enable field positions
  localparam int unsigned RXQ_EN_BIT  = 0;
  localparam int unsigned RXQ_TM_BIT  = 2;
  localparam int unsigned RXQ_LVL_LSB = 8;
  localparam int unsigned RCV_EN_BIT  = 0;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h00;
  localparam logic [STAT_W-1:0] STAT_RST  = 5'h00;
  localparam logic [LVL_W-1:0]  LVL_RST   = 4'h1;
  localparam logic              RXQ_EN_RST = 1'b0;
  localparam logic              RXQ_TM_RST = 1'b0;
  localparam logic              RCV_RST   = 1'b0;

  // Receive queue depth
  localparam int unsigned FIFO_DEPTH_DEF = 8;
  localparam int unsigned FIFO_DEPTH_MAX = 15;

  // Autobaud characters
  localparam logic [CHAR_W-1:0] CHAR_LOWER_A = 8'h61;
  localparam logic [CHAR_W-1:0] CHAR_UPPER_A = 8'h41;
  localparam logic [CHAR_W-1:0] CHAR_LOWER_T = 8'h74;
  localparam logic [CHAR_W-1:0] CHAR_UPPER_T = 8'h54;

  typedef struct packed {
    logic first_char_irq_enable;
    logic detect_done_irq_enable;
    logic detect_start_irq_enable;
    logic auto_receiver_gate;
    logic baud_detect_enable;
  } abd_ctrl_t;

  typedef struct packed {
    logic waiting_first_char;
    logic second_char_upper_seen;
    logic second_char_lower_seen;
    logic first_char_upper_seen;
    logic first_char_lower_seen;
  } abd_stat_t;

  typedef struct packed {
    logic [LVL_W-1:0] rx_trigger_level;
    logic             rx_transparent_enable;
    logic             rx_queue_enable;
  } abd_rxq_t;

  typedef struct packed {
    logic upper_t;
    logic lower_t;
    logic upper_a;
    logic lower_a;
  } abd_hit_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FIRST  = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_DONE   = 4'b1000
  } abd_state_t;

endpackage
`default_nettype wire

/* File: hdl/abd_top.sv */
`default_nettype none
module abd_top #(
  parameter int unsigned FIFO_DEPTH = abd_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // Register port
  input  wire logic [abd_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [abd_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [abd_pkg::DATA_W-1:0] reg_rdata,
  // Receiver datapath
  input  wire logic                       rx_char_valid,
  input  wire logic [abd_pkg::CHAR_W-1:0] rx_char_data,
  input  wire logic [abd_pkg::LVL_W-1:0]  rx_fill_level,
  // Control outputs
  output logic                            receiver_enable,
  output logic                            rx_queue_enable,
  output logic                            rx_transparent_enable,
  // Requests
  output logic                            detect_start_irq,
  output logic                            detect_done_irq,
  output logic                            receive_irq
);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > abd_pkg::FIFO_DEPTH_MAX) begin : g_bad_depth
    $error("FIFO_DEPTH must lie between 1 and 15");
  end

  abd_pkg::abd_ctrl_t               ctrl_r;
  abd_pkg::abd_stat_t               stat_r;
  abd_pkg::abd_rxq_t                rxq_r;
  abd_pkg::abd_state_t              st_r;
  abd_pkg::abd_hit_t                hit;
  abd_pkg::abd_ctrl_t               wctrl;
  logic                             rcv_en_r;
  logic                             start_irq_r;
  logic                             done_irq_r;
  logic                             rx_irq_r;
  logic [abd_pkg::DATA_W-1:0]       rdata_r;
  logic [abd_pkg::DATA_W-1:0]       rdata_nxt;
  logic                             wr_ctrl;
  logic                             wr_stat;
  logic                             wr_rxq;
  logic                             wr_rcv;
  logic                             en_rise;
  logic                             abort;
  logic                             hunting;
  logic                             take_first;
  logic                             take_second;
  logic                             lvl_reached;

  // Flags after a hit: only the new flag stays, waiting drops
  function automatic abd_pkg::abd_stat_t hit_flags(input abd_pkg::abd_hit_t h,
                                                   input logic second);
    abd_pkg::abd_stat_t s;
    s = '0;
    if (second) begin
      s.second_char_upper_seen = h.upper_t;
      s.second_char_lower_seen = h.lower_t;
    end else begin
      s.first_char_upper_seen = h.upper_a;
      s.first_char_lower_seen = h.lower_a;
    end
    return s;
  endfunction

  function automatic logic [abd_pkg::DATA_W-1:0] zext5(input logic [4:0] v);
    return {{(abd_pkg::DATA_W-5){1'b0}}, v};
  endfunction

  abd_char_match u_match (
    .char_valid (rx_char_valid),
    .char_data  (rx_char_data),
    .hit        (hit)
  );

  // Decode
  assign wr_ctrl = reg_wr && (reg_addr == abd_pkg::OFS_CTRL);
  assign wr_stat = reg_wr && (reg_addr == abd_pkg::OFS_STAT);
  assign wr_rxq  = reg_wr && (reg_addr == abd_pkg::OFS_RXQ);
  assign wr_rcv  = reg_wr && (reg_addr == abd_pkg::OFS_RCV);
  assign wctrl   = abd_pkg::abd_ctrl_t'(reg_wdata[abd_pkg::CTRL_W-1:0]);

  assign en_rise = wr_ctrl && wctrl.baud_detect_enable && !ctrl_r.baud_detect_enable;
  assign abort   = wr_ctrl && !wctrl.baud_detect_enable && ctrl_r.baud_detect_enable;
  assign hunting = (st_r == abd_pkg::ST_FIRST) || (st_r == abd_pkg::ST_SECOND);

  // A fresh a/A restarts the pair even while waiting for t/T
  assign take_first  = hunting && !abort && (hit.lower_a || hit.upper_a);
  assign take_second = (st_r == abd_pkg::ST_SECOND) && !abort &&
                       (hit.lower_t || hit.upper_t);

  // Detection sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= abd_pkg::ST_IDLE;
    end else if (abort) begin
      st_r <= abd_pkg::ST_IDLE;
    end else begin
      case (st_r)
        abd_pkg::ST_IDLE: begin
          if (en_rise) begin
            st_r <= abd_pkg::ST_FIRST;
          end
        end
        abd_pkg::ST_FIRST: begin
          if (take_first) begin
            st_r <= abd_pkg::ST_SECOND;
          end
        end
        abd_pkg::ST_SECOND: begin
          if (take_second) begin
            st_r <= abd_pkg::ST_DONE;
          end else if (rx_char_valid && !take_first) begin
            st_r <= abd_pkg::ST_FIRST;
          end
        end
        abd_pkg::ST_DONE: begin
          st_r <= abd_pkg::ST_IDLE;
        end
        default: begin
          st_r <= abd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= abd_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wctrl;
      end
      // Cleared one cycle after the second flag is set
      if (st_r == abd_pkg::ST_DONE) begin
        ctrl_r.baud_detect_enable <= 1'b0;
      end
    end
  end

  // Status flags; hardware events are applied after the software write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= abd_pkg::STAT_RST;
    end else begin
      if (wr_stat) begin
        stat_r <= abd_pkg::abd_stat_t'(reg_wdata[abd_pkg::STAT_W-1:0]);
      end
      if (en_rise) begin
        stat_r                    <= '0;
        stat_r.waiting_first_char <= 1'b1;
      end else if (take_second) begin
        stat_r <= hit_flags(hit, 1'b1);
      end else if (take_first) begin
        stat_r <= hit_flags(hit, 1'b0);
      end
    end
  end

  // Receive queue control
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxq_r.rx_trigger_level      <= abd_pkg::LVL_RST;
      rxq_r.rx_transparent_enable <= abd_pkg::RXQ_TM_RST;
      rxq_r.rx_queue_enable       <= abd_pkg::RXQ_EN_RST;
    end else if (wr_rxq) begin
      rxq_r.rx_trigger_level      <=
        reg_wdata[abd_pkg::RXQ_LVL_LSB +: abd_pkg::LVL_W];
      rxq_r.rx_transparent_enable <= reg_wdata[abd_pkg::RXQ_TM_BIT];
      rxq_r.rx_queue_enable       <= reg_wdata[abd_pkg::RXQ_EN_BIT];
    end
  end

  // Receiver enable: software owns it unless gated detection is running
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcv_en_r <= abd_pkg::RCV_RST;
    end else begin
      if (wr_rcv) begin
        rcv_en_r <= reg_wdata[abd_pkg::RCV_EN_BIT];
      end
      if (take_second && ctrl_r.auto_receiver_gate) begin
        rcv_en_r <= 1'b1;
      end else if (en_rise && wctrl.auto_receiver_gate) begin
        rcv_en_r <= 1'b0;
      end else if (hunting && ctrl_r.auto_receiver_gate && !abort) begin
        rcv_en_r <= 1'b0;
      end
    end
  end

  // Fill level already counts the byte just stored
  assign lvl_reached = rx_fill_level >= rxq_r.rx_trigger_level;

  // Requests, one-cycle pulses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_irq_r <= 1'b0;
      done_irq_r  <= 1'b0;
      rx_irq_r    <= 1'b0;
    end else begin
      start_irq_r <= en_rise && wctrl.detect_start_irq_enable;
      done_irq_r  <= ctrl_r.detect_done_irq_enable &&
                     ((st_r == abd_pkg::ST_DONE) ||
                      (take_first && ctrl_r.first_char_irq_enable));
      // Without a queue, or in transparent mode, every byte asks
      rx_irq_r    <= rx_char_valid && (!rxq_r.rx_queue_enable ||
                     rxq_r.rx_transparent_enable || lvl_reached);
    end
  end

  // Read path
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        abd_pkg::OFS_CTRL: begin
          rdata_nxt = zext5(ctrl_r);
        end
        abd_pkg::OFS_STAT: begin
          rdata_nxt = zext5(stat_r);
        end
        abd_pkg::OFS_RXQ: begin
          rdata_nxt[abd_pkg::RXQ_LVL_LSB +: abd_pkg::LVL_W] = rxq_r.rx_trigger_level;
          rdata_nxt[abd_pkg::RXQ_TM_BIT] = rxq_r.rx_transparent_enable;
          rdata_nxt[abd_pkg::RXQ_EN_BIT] = rxq_r.rx_queue_enable;
        end
        abd_pkg::OFS_RCV: begin
          rdata_nxt[abd_pkg::RCV_EN_BIT] = rcv_en_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata             = rdata_r;
  assign receiver_enable       = rcv_en_r;
  assign rx_queue_enable       = rxq_r.rx_queue_enable;
  assign rx_transparent_enable = rxq_r.rx_transparent_enable;
  assign detect_start_irq      = start_irq_r;
  assign detect_done_irq       = done_irq_r;
  assign receive_irq           = rx_irq_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_second_char;
    take_second;
  endsequence

  sequence s_flag_stage;
    (stat_r.second_char_upper_seen || stat_r.second_char_lower_seen) &&
    ctrl_r.baud_detect_enable && (st_r == abd_pkg::ST_DONE);
  endsequence

  sequence s_clear_stage;
    !ctrl_r.baud_detect_enable && (st_r == abd_pkg::ST_IDLE);
  endsequence

  a_start_req_gate:
  assert property (detect_start_irq |-> ctrl_r.detect_start_irq_enable &&
                   stat_r.waiting_first_char)
    else $error("start request without its enable");

  a_gate_holds_off:
  assert property (hunting && ctrl_r.auto_receiver_gate && !abort && !take_second
                   |=> !receiver_enable)
    else $error("receiver enabled while gated detection runs");

  a_gate_release:
  assert property (s_second_char ##0 ctrl_r.auto_receiver_gate |=> receiver_enable)
    else $error("receiver not enabled after detection");

  a_rx_untouched:
  assert property (!ctrl_r.auto_receiver_gate && !en_rise && !wr_rcv
                   |=> $stable(receiver_enable))
    else $error("receiver enable moved without gate");

  a_success_order:
  assert property (s_second_char |=> s_flag_stage ##1 s_clear_stage)
    else $error("second flag and enable clear out of order");

  a_abort_idle:
  assert property (abort |=> st_r == abd_pkg::ST_IDLE && !ctrl_r.baud_detect_enable)
    else $error("abort did not stop detection");

  a_start_flags:
  assert property (en_rise |=> stat_r.waiting_first_char &&
                   stat_r[3:0] == 4'h0 && st_r == abd_pkg::ST_FIRST)
    else $error("enable set without waiting flag");

  a_first_hit:
  assert property (take_first && !take_second |=> !stat_r.waiting_first_char &&
                   $countones(stat_r[1:0]) == 1 && stat_r[3:2] == 2'h0)
    else $error("first character flags wrong");

  a_done_req_gate:
  assert property (!ctrl_r.detect_done_irq_enable && !wr_ctrl |=> !detect_done_irq)
    else $error("done request while disabled");

  a_rx_level:
  assert property (rx_char_valid && rxq_r.rx_queue_enable &&
                   !rxq_r.rx_transparent_enable && !lvl_reached |=> !receive_irq)
    else $error("receive request below trigger level");

  a_rx_per_byte:
  assert property (rx_char_valid && rxq_r.rx_transparent_enable |=> receive_irq)
    else $error("transparent mode missed a receive request");

endmodule
`default_nettype wire

/* File: test/abd_term_model.sv */
`default_nettype none
module abd_term_model (
  // Clock
  input  wire logic                       core_clk,
  // Characters toward the receiver
  output logic                            char_valid,
  output logic      [abd_pkg::CHAR_W-1:0] char_data,
  output logic      [abd_pkg::LVL_W-1:0]  fill_level
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    char_valid = 1'b0;
    char_data  = 8'hA5;
    fill_level = 4'h0;
  end

  // Data inverted outside the stop-bit pulse so a stale byte never matches
  task automatic send(input logic [abd_pkg::CHAR_W-1:0] c,
                      input logic [abd_pkg::LVL_W-1:0]  fill,
                      input int                          gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    char_valid <= 1'b1;
    char_data  <= c;
    fill_level <= fill;
    @(posedge core_clk);
    char_valid <= 1'b0;
    char_data  <= ~c;
  endtask
endmodule
`default_nettype wire

/* File: test/abd_top_tb.sv */
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module abd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                       core_clk;
  logic                       rst_n;
  logic [abd_pkg::ADDR_W-1:0] reg_addr;
  logic [abd_pkg::DATA_W-1:0] reg_wdata;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [abd_pkg::DATA_W-1:0] reg_rdata;
  logic                       rx_char_valid;
  logic [abd_pkg::CHAR_W-1:0] rx_char_data;
  logic [abd_pkg::LVL_W-1:0]  rx_fill_level;
  logic                       receiver_enable;
  logic                       rx_queue_enable;
  logic                       rx_transparent_enable;
  logic                       detect_start_irq;
  logic                       detect_done_irq;
  logic                       receive_irq;
  int                         bad_count;
  int                         n_compared;

  abd_top #(.FIFO_DEPTH(8)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_fill_level(rx_fill_level), .receiver_enable(receiver_enable),
    .rx_queue_enable(rx_queue_enable), .rx_transparent_enable(rx_transparent_enable),
    .detect_start_irq(detect_start_irq), .detect_done_irq(detect_done_irq),
    .receive_irq(receive_irq));

  abd_term_model term (
    .core_clk(core_clk), .char_valid(rx_char_valid), .char_data(rx_char_data),
    .fill_level(rx_fill_level));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [abd_pkg::ADDR_W-1:0] a, input logic [abd_pkg::DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic rd_chk(input logic [abd_pkg::ADDR_W-1:0] a,
                        input logic [abd_pkg::DATA_W-1:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK(reg_rdata, exp)
  endtask

  // Receive request seen one cycle after the stop-bit pulse
  task automatic rx_irq(input logic [abd_pkg::LVL_W-1:0] fill, input logic exp);
    term.send(8'h5A, fill, 0);
    @(negedge core_clk);
    `CHK(receive_irq, exp)
  endtask

  task automatic t_reset_map();
    rd_chk(abd_pkg::OFS_CTRL, 16'h0000);
    rd_chk(abd_pkg::OFS_STAT, 16'h0000);
    rd_chk(abd_pkg::OFS_RXQ, 16'h0100);
    rd_chk(4'hF, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd_chk(abd_pkg::OFS_CTRL, 16'h0000);
    wr(abd_pkg::OFS_STAT, 16'hFFE0);
    rd_chk(abd_pkg::OFS_STAT, 16'h0000);
    wr(abd_pkg::OFS_RXQ, 16'hFFFF);
    rd_chk(abd_pkg::OFS_RXQ, 16'h0F05);
    `CHK(rx_queue_enable, 1'b1)
    `CHK(rx_transparent_enable, 1'b1)
  endtask

  task automatic t_detect_gated();
    wr(abd_pkg::OFS_RCV, 16'h0001);
    wr(abd_pkg::OFS_CTRL, 16'h000F);
    @(negedge core_clk);
    `CHK(detect_start_irq, 1'b1)
    `CHK(receiver_enable, 1'b0)
    rd_chk(abd_pkg::OFS_STAT, 16'h0010);
    term.send(abd_pkg::CHAR_LOWER_A, 4'h1, 0);
    rd_chk(abd_pkg::OFS_STAT, 16'h0001);
    `CHK(receiver_enable, 1'b0)
    term.send(abd_pkg::CHAR_UPPER_T, 4'h2, 0);
    @(negedge core_clk);
    `CHK(receiver_enable, 1'b1)
    `CHK(detect_done_irq, 1'b0)
    @(negedge core_clk);
    `CHK(detect_done_irq, 1'b1)
    rd_chk(abd_pkg::OFS_STAT, 16'h0008);
    rd_chk(abd_pkg::OFS_CTRL, 16'h000E);
  endtask

  task automatic t_detect_plain();
    wr(abd_pkg::OFS_CTRL, 16'h0001);
    @(negedge core_clk);
    `CHK(detect_start_irq, 1'b0)
    term.send(abd_pkg::CHAR_UPPER_A, 4'h3, 0);
    term.send(abd_pkg::CHAR_LOWER_T, 4'h4, 0);
    @(negedge core_clk);
    @(negedge core_clk);
    `CHK(detect_done_irq, 1'b0)
    `CHK(receiver_enable, 1'b1)
    rd_chk(abd_pkg::OFS_STAT, 16'h0004);
    rd_chk(abd_pkg::OFS_CTRL, 16'h0000);
    wr(abd_pkg::OFS_CTRL, 16'h0001);
    term.send(abd_pkg::CHAR_UPPER_A, 4'h1, 2);
    rd_chk(abd_pkg::OFS_STAT, 16'h0002);
    `CHK(receiver_enable, 1'b1)
  endtask

  task automatic t_abort();
    wr(abd_pkg::OFS_CTRL, 16'h0000);
    wr(abd_pkg::OFS_CTRL, 16'h0019);
    rd_chk(abd_pkg::OFS_STAT, 16'h0010);
    wr(abd_pkg::OFS_STAT, 16'h0000);
    rd_chk(abd_pkg::OFS_STAT, 16'h0000);
    term.send(abd_pkg::CHAR_LOWER_A, 4'h1, 0);
    @(negedge core_clk);
    `CHK(detect_done_irq, 1'b1)
    rd_chk(abd_pkg::OFS_STAT, 16'h0001);
    wr(abd_pkg::OFS_CTRL, 16'h0000);
    term.send(abd_pkg::CHAR_UPPER_T, 4'h2, 0);
    rd_chk(abd_pkg::OFS_STAT, 16'h0001);
    rd_chk(abd_pkg::OFS_CTRL, 16'h0000);
  endtask

  // Levels stay within the depth of 8 and never use the reserved code
  task automatic t_rx_level();
    wr(abd_pkg::OFS_RXQ, 16'h0301);
    rx_irq(4'h2, 1'b0);
    rx_irq(4'h3, 1'b1);
    rx_irq(4'h4, 1'b1);
    wr(abd_pkg::OFS_RXQ, 16'h0801);
    rx_irq(4'h7, 1'b0);
    rx_irq(4'h8, 1'b1);
    wr(abd_pkg::OFS_RXQ, 16'h0805);
    rx_irq(4'h1, 1'b1);
    wr(abd_pkg::OFS_RXQ, 16'h0800);
    @(negedge core_clk);
    `CHK(rx_queue_enable, 1'b0)
    `CHK(rx_transparent_enable, 1'b0)
    rx_irq(4'h1, 1'b1);
    wr(abd_pkg::OFS_RXQ, 16'h0804);
    rx_irq(4'h1, 1'b1);
  endtask

  initial begin
    bad_count  = 0;
    n_compared = 0;
    rst_n      = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_map();
    t_detect_gated();
    t_detect_plain();
    t_abort();
    t_rx_level();
    give_verdict();
  end

  // Whole run needs well under two hundred cycles
  initial begin
    #300000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
